/* logic/serial_port_defs.svh */
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH
// ==========================================================
// Instruction byte fields
`define INSTR_DIR_BIT 7
`define INSTR_CNT_HI 6
`define INSTR_CNT_LO 5
`define INSTR_ADDR_HI 4
// ==========================================================
// Port configuration register (address 0) fields
`define CFG_ADDR 5'h00
`define CFG_PIN_SEL_BIT 7
`define CFG_ORDER_BIT 6
`define CFG_RESET_VAL 8'h00
// ==========================================================
// Timing
`define CORE_CLK_MHZ 10
`define BITS_PER_BYTE 4'h8
`endif

/* logic/serial_port_pkg.sv */
package serial_port_pkg;
  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_INSTR = 3'b010,
    ST_DATA  = 3'b100
  } port_state_e;
  typedef logic [4:0] reg_addr_t;
endpackage : serial_port_pkg

/* logic/pin_sync.sv */
// ==========================================================
// Two-flop synchroniser for pins from outside the core clock domain
module pin_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // Asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_r;

  // First stage is read only by the second stage
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_r <= '0;
      o_sync <= '0;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule : pin_sync

/* logic/serial_control_port.sv */
// Overview of operation
// R1 - Each cycle starts with an instruction byte on the first eight rising clocks.
// R2 - Instruction bit 7 high means read, low means write.
// R3 - Instruction bits 6:5 give one to four data bytes.
// R4 - Bits 4:0 give the first address; later addresses are generated internally.
// R5 - Select high then low restarts sequencing at the instruction phase.
// R6 - An abandoned partial byte is discarded and never written.
// R7 - Each written byte updates its register as soon as its last bit arrives.
// R8 - Clocks after the instruction carry the data bytes in the chosen direction.
// R9 - Supports one shared data pin or separate input and output pins.
// R10 - Supports single and multibyte transfers, MSB-first or LSB-first.
// R11 - Controller should prefer one multibyte transfer over many single ones.
// R12 - Every configuration register is readable and writable.
// R13 - Sample on rising serial clock, drive on falling serial clock.
// R14 - Data pins float while deselected; output pin floats in shared-pin mode.
// R15 - Register 0 bit 7 selects pin arrangement, default input-only shared pin.
// R16 - Register 0 bit 6: clear MSB-first decrementing, set LSB-first incrementing.
// R17 - Reads shift out all eight bits of each addressed register.
// R18 - Controller holds select low and gives exactly eight clocks per byte.
`include "serial_port_defs.svh"

module serial_control_port
  import serial_port_pkg::*;
#(
  parameter int NUM_REGS = 32
) (
  // Core clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // Serial pins (sampled through synchronisers)
  input wire logic i_serial_clk,
  input wire logic i_port_select_n,
  input wire logic i_sdio,
  // Shared data pin drive
  output logic o_sdio,
  output logic o_sdio_oe,
  // Separate output pin
  output logic o_serial_out_line,
  output logic o_serial_out_line_oe,
  // Register image and write strobe to the device
  output logic [NUM_REGS*8-1:0] o_regs,
  output logic o_reg_wr,
  output logic [4:0] o_reg_wr_addr,
  // Configuration bits of register 0
  output logic o_pin_arrangement_sel,
  output logic o_bit_order_sel
);
  // ==========================================================
  // Synchronised pins and edge detect
  logic [2:0] sync_w;
  logic sclk_d_r;
  logic sclk_s;
  logic cs_n_s;
  logic sdi_s;
  logic rise_w;
  logic fall_w;

  pin_sync #(.WIDTH(3)) u_sync (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_async({i_serial_clk, i_port_select_n, i_sdio}),
    .o_sync(sync_w)
  );
  assign sclk_s = sync_w[2];
  assign cs_n_s = sync_w[1];
  assign sdi_s = sync_w[0];
  assign rise_w = sclk_s & ~sclk_d_r & ~cs_n_s; // see R13
  assign fall_w = ~sclk_s & sclk_d_r & ~cs_n_s; // see R13

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) sclk_d_r <= 1'b0;
    else sclk_d_r <= sclk_s;
  end

  // ==========================================================
  // Sequencer state
  port_state_e state_r, state_nxt;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic is_read_r;
  logic [1:0] bytes_left_r;
  reg_addr_t addr_r;
  logic [7:0] regs_r [NUM_REGS];
  logic [7:0] tx_r;
  logic out_r;
  logic drive_r;
  logic armed_r;

  // Order from register 0 takes effect immediately, even mid-cycle
  wire lsb_first_w = regs_r[0][`CFG_ORDER_BIT];
  wire pin_shared_w = regs_r[0][`CFG_PIN_SEL_BIT];

  // Shift in one bit according to bit order
  function automatic logic [7:0] shift_in(input logic [7:0] cur, input logic b, input logic lsb);
    shift_in = lsb ? {b, cur[7:1]} : {cur[6:0], b};
  endfunction : shift_in

  // Next byte address: decrement MSB-first, increment LSB-first, wrapping in 5 bits
  function automatic reg_addr_t next_addr(input reg_addr_t a, input logic lsb);
    next_addr = lsb ? reg_addr_t'(a + 5'h01) : reg_addr_t'(a - 5'h01);
  endfunction : next_addr

  wire [7:0] byte_w = shift_in(shift_r, sdi_s, lsb_first_w);
  wire last_bit_w = rise_w && (bit_cnt_r == `BITS_PER_BYTE - 4'h1);
  wire instr_done_w = (state_r == ST_INSTR) && last_bit_w; // see R1
  wire data_done_w = (state_r == ST_DATA) && last_bit_w;
  wire wr_byte_w = data_done_w && !is_read_r; // see R7
  wire [7:0] rd_byte_w = regs_r[instr_done_w ? byte_w[`INSTR_ADDR_HI:0] : next_addr(addr_r, lsb_first_w)];
  // Value register 0 takes at this edge, so the mode outputs move with the write strobe
  wire [7:0] cfg_nxt_w = (wr_byte_w && addr_r == `CFG_ADDR) ? byte_w : regs_r[0];

  // State transitions; select high always returns to idle
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (!cs_n_s && armed_r) state_nxt = ST_INSTR; // see R5
      ST_INSTR: if (instr_done_w) state_nxt = ST_DATA; // see R8
      ST_DATA: if (data_done_w && bytes_left_r == 2'b00) state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
    if (cs_n_s) state_nxt = ST_IDLE; // see R5
  end

  // Armed only once select is seen high; trailing clocks after the last byte
  // and the synchroniser fill after reset can then never start a new cycle
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      armed_r <= 1'b0;
    end else if (cs_n_s) begin
      armed_r <= 1'b1; // see R5
    end else if (state_r == ST_INSTR) begin
      armed_r <= 1'b0;
    end
  end

  // Bit counter and shifter; partial bytes are dropped when select rises
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      if (cs_n_s || state_r == ST_IDLE) begin
        bit_cnt_r <= 4'h0; // see R6
        shift_r <= 8'h00;
      end else if (rise_w) begin
        bit_cnt_r <= last_bit_w ? 4'h0 : bit_cnt_r + 4'h1;
        shift_r <= byte_w;
      end
    end
  end

  // Instruction decode and address generation
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      is_read_r <= 1'b0;
      bytes_left_r <= 2'b00;
      addr_r <= 5'h00;
    end else if (instr_done_w) begin
      is_read_r <= byte_w[`INSTR_DIR_BIT]; // see R2
      bytes_left_r <= byte_w[`INSTR_CNT_HI:`INSTR_CNT_LO]; // see R3, R10
      addr_r <= byte_w[`INSTR_ADDR_HI:0]; // see R4
    end else if (data_done_w) begin
      bytes_left_r <= bytes_left_r - 2'b01;
      addr_r <= next_addr(addr_r, lsb_first_w); // see R4, R16
    end
  end

  // Register file: every address writable and readable
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < NUM_REGS; i++) regs_r[i] <= (i == 0) ? `CFG_RESET_VAL : 8'h00; // see R15
    end else if (wr_byte_w) begin
      regs_r[addr_r] <= byte_w; // see R7, R12
    end
  end

  // Read shifter: load at each byte boundary, shift on falling clock
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_r <= 8'h00;
      out_r <= 1'b0;
      drive_r <= 1'b0;
    end else begin
      if (cs_n_s) drive_r <= 1'b0; // see R14
      else if (instr_done_w) drive_r <= byte_w[`INSTR_DIR_BIT];
      else if (data_done_w && bytes_left_r == 2'b00) drive_r <= 1'b0;
      if ((instr_done_w && byte_w[`INSTR_DIR_BIT]) || (data_done_w && is_read_r && bytes_left_r != 2'b00)) begin
        tx_r <= rd_byte_w; // see R17
      end else if (fall_w && drive_r) begin
        out_r <= lsb_first_w ? tx_r[0] : tx_r[7]; // see R13, R17
        tx_r <= lsb_first_w ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
      end
    end
  end

  // Pin drivers registered so every output comes from a flip-flop
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_sdio <= 1'b0;
      o_sdio_oe <= 1'b0;
      o_serial_out_line <= 1'b0;
      o_serial_out_line_oe <= 1'b0;
      o_reg_wr <= 1'b0;
      o_reg_wr_addr <= 5'h00;
    end else begin
      o_sdio <= out_r;
      o_serial_out_line <= out_r;
      o_sdio_oe <= drive_r && pin_shared_w && !cs_n_s; // see R9, R14, R15
      o_serial_out_line_oe <= drive_r && !pin_shared_w && !cs_n_s; // see R9, R14
      o_reg_wr <= wr_byte_w;
      o_reg_wr_addr <= addr_r;
    end
  end

  // Flattened register image for the device logic
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_regs <= '0;
      o_pin_arrangement_sel <= 1'b0;
      o_bit_order_sel <= 1'b0;
    end else begin
      // Written byte is forwarded so the image changes together with o_reg_wr
      for (int i = 0; i < NUM_REGS; i++) begin
        o_regs[i*8 +: 8] <= (wr_byte_w && addr_r == reg_addr_t'(i)) ? byte_w : regs_r[i]; // see R7
      end
      o_pin_arrangement_sel <= cfg_nxt_w[`CFG_PIN_SEL_BIT]; // see R15
      o_bit_order_sel <= cfg_nxt_w[`CFG_ORDER_BIT]; // see R16
    end
  end
endmodule : serial_control_port

/* verification/serial_control_port_checker.sv */
// ==========================================
// Port properties of the serial control port
module serial_control_port_checker #(
  parameter int NUM_REGS = 32
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // Watched pins and register image
  input wire logic i_port_select_n,
  input wire logic o_sdio_oe,
  input wire logic o_serial_out_line_oe,
  input wire logic [NUM_REGS*8-1:0] o_regs,
  input wire logic o_reg_wr,
  input wire logic o_pin_arrangement_sel,
  input wire logic o_bit_order_sel
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  // Six idle cycles cover the select synchroniser and the output register
  property p_idle_float; i_port_select_n [*6] |-> !o_sdio_oe && !o_serial_out_line_oe; endproperty
  a_idle_float: assert property (p_idle_float) else $error("pin driven while idle");
  property p_sep_mode; o_serial_out_line_oe |-> !o_pin_arrangement_sel; endproperty
  a_sep_mode: assert property (p_sep_mode) else $error("output pin in shared mode");
  property p_shared_mode; o_sdio_oe |-> o_pin_arrangement_sel; endproperty
  a_shared_mode: assert property (p_shared_mode) else $error("shared pin driven");
  property p_wr_pulse; o_reg_wr |=> !o_reg_wr; endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse too long");
  property p_no_wr_idle; i_port_select_n [*8] |-> !o_reg_wr; endproperty
  a_no_wr_idle: assert property (p_no_wr_idle) else $error("write while idle");
  property p_wr_dir; o_reg_wr |-> !o_sdio_oe && !o_serial_out_line_oe; endproperty
  a_wr_dir: assert property (p_wr_dir) else $error("write during read");
  property p_regs_by_wr; $changed(o_regs) |-> o_reg_wr; endproperty
  a_regs_by_wr: assert property (p_regs_by_wr) else $error("register change without write");
  property p_pin_cfg; $changed(o_regs[7]) |-> ##[0:1] o_pin_arrangement_sel == o_regs[7]; endproperty
  a_pin_cfg: assert property (p_pin_cfg) else $error("pin mode not applied");
  property p_order_cfg; $changed(o_regs[6]) |-> ##[0:1] o_bit_order_sel == o_regs[6]; endproperty
  a_order_cfg: assert property (p_order_cfg) else $error("bit order not applied");
  c_wr: cover property (o_reg_wr);
  c_sdio: cover property ($rose(o_sdio_oe));
  c_sep: cover property ($rose(o_serial_out_line_oe));
endmodule : serial_control_port_checker

bind serial_control_port serial_control_port_checker #(.NUM_REGS(NUM_REGS)) u_serial_control_port_checker (
  .i_core_clk, .i_arst_n, .i_port_select_n, .o_sdio_oe, .o_serial_out_line_oe, .o_regs, .o_reg_wr,
  .o_pin_arrangement_sel, .o_bit_order_sel);

/* verification/spi_master_model.sv */
// ==========================================
// Serial bus controller model
module spi_master_model (
  // Core clock and returned data
  input wire logic i_core_clk,
  input wire logic i_miso,
  // Serial pins
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi
);
  timeunit 1ns;
  timeprecision 1ns;
  // Clock stands high between frames
  initial begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  // Instruction in tx[7:0], then data bytes; fewer bits abandons the frame
  task automatic frame(input logic [39:0] tx, input int nb, input bit lsb, output logic [31:0] rx);
    int b;
    rx = '0;
    @(posedge i_core_clk) o_cs_n <= 1'b0;
    repeat (4) @(posedge i_core_clk);
    for (int i = 0; i < nb; i++) begin
      b = lsb ? i % 8 : 7 - i % 8;
      o_sclk <= 1'b0;
      o_mosi <= tx[8*(i/8)+b];
      repeat (4) @(posedge i_core_clk);
      o_sclk <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      // Late sampling, data stands until the next falling edge
      @(negedge i_core_clk) if (i >= 8) rx[8*(i/8-1)+b] = i_miso;
      @(posedge i_core_clk);
    end
    repeat (3) @(posedge i_core_clk);
    o_cs_n <= 1'b1;
    repeat (6) @(posedge i_core_clk);
  endtask : frame
endmodule : spi_master_model

/* verification/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import serial_port_pkg::*;
  logic i_core_clk = 1'b0, i_arst_n = 1'b0, tick = 1'b0, mosi;
  logic i_serial_clk, i_port_select_n, o_sdio, o_sdio_oe, o_serial_out_line, o_serial_out_line_oe;
  logic o_reg_wr, o_pin_arrangement_sel, o_bit_order_sel;
  logic [4:0] o_reg_wr_addr;
  logic [255:0] o_regs;
  logic [7:0] mem [32] = '{default: 8'h00};
  logic [12:0] q [$];
  int num_errors = 0, num_checks = 0;
  // A released separate output line shows a toggling pattern; a released shared pin shows the controller's data
  wire i_sdio = o_sdio_oe ? o_sdio : mosi;
  wire miso = o_pin_arrangement_sel ? i_sdio : (o_serial_out_line_oe ? o_serial_out_line : tick);
  serial_control_port u_serial_control_port (.i_core_clk, .i_arst_n, .i_serial_clk, .i_port_select_n,
    .i_sdio, .o_sdio, .o_sdio_oe, .o_serial_out_line, .o_serial_out_line_oe, .o_regs, .o_reg_wr,
    .o_reg_wr_addr, .o_pin_arrangement_sel, .o_bit_order_sel);
  spi_master_model u_spi_master_model (.i_core_clk, .i_miso(miso), .o_sclk(i_serial_clk),
    .o_cs_n(i_port_select_n), .o_mosi(mosi));
  initial forever #50 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) tick <= ~tick;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task end_sim;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  // Each write pulse takes the oldest note; a write with no note is a mismatch
  always @(negedge i_core_clk) if (o_reg_wr === 1'b1) begin
    chk(8'(q.size() > 0), 8'h01);
    if (q.size() > 0) begin
      chk({3'h0, o_reg_wr_addr}, {3'h0, q[0][12:8]});
      chk(o_regs[o_reg_wr_addr*8+:8], q.pop_front() & 8'hFF);
    end
  end
  task automatic wr(input logic [4:0] a, input int n, input bit lsb, input logic [31:0] d);
    logic [4:0] x;
    logic [31:0] r;
    for (int k = 0; k < n; k++) begin
      x = lsb ? a + 5'(k) : a - 5'(k);
      mem[x] = d[8*k+:8];
      q.push_back({x, d[8*k+:8]});
    end
    u_spi_master_model.frame({d, 1'b0, 2'(n - 1), a}, 8 + 8 * n, lsb, r);
  endtask : wr
  task automatic rd(input logic [4:0] a, input int n, input bit lsb);
    logic [31:0] r;
    u_spi_master_model.frame({32'h0, 1'b1, 2'(n - 1), a}, 8 + 8 * n, lsb, r);
    for (int k = 0; k < n; k++) chk(r[8*k+:8], mem[lsb ? a + 5'(k) : a - 5'(k)]);
  endtask : rd
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [31:0] r;
    void'($urandom(9));
    repeat (5) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    for (int i = 0; i < 32; i++) chk(o_regs[i*8+:8], 8'h00);
    $display("test reset done");
    for (int n = 1; n < 5; n++) begin
      d = $urandom;
      if (n == 4) d[23:16] = 8'h00;
      wr(n == 4 ? 5'h02 : 5'(6 * n), n, 1'b0, d);
    end
    rd(5'h02, 4, 1'b0);
    rd(5'h12, 3, 1'b0);
    $display("test msb first done");
    d = $urandom;
    u_spi_master_model.frame({d, 8'h06}, 13, 1'b0, r);
    chk(o_regs[6*8+:8], mem[6]);
    wr(5'h06, 1, 1'b0, d);
    $display("test abandon done");
    wr(5'h00, 1, 1'b0, 32'hC0);
    d = $urandom;
    wr(5'h1F, 2, 1'b1, {16'h0, 8'hC0, d[7:0]});
    rd(5'h1E, 3, 1'b1);
    chk(8'(q.size()), 8'h00);
    $display("test lsb shared done");
    end_sim();
  end
  initial begin
    #5000000;
    num_errors++;
    end_sim();
  end
endmodule : tb
